/* hw/tla_params.svh */
`ifndef TLA_PARAMS_SVH
`define TLA_PARAMS_SVH

// register byte addresses
`define TLA_ADDR_CFG1        8'h00
`define TLA_ADDR_CONSEC      8'h04
`define TLA_ADDR_STAT1       8'h08
`define TLA_ADDR_STAT2       8'h0C
`define TLA_ADDR_LIM_BASE    8'h10
`define TLA_LIM_STRIDE       8'h08
`define TLA_LIM_LOW_OFS      8'h04
`define TLA_ADDR_FS_LOCAL    8'h28
`define TLA_ADDR_FS_REMOTE   8'h2C
`define TLA_ADDR_HYST        8'h30
`define TLA_ADDR_TEMP_BASE   8'h34
`define TLA_TEMP_STRIDE      8'h04

// configuration bit positions
`define TLA_CFG_MASK_ALL     7
`define TLA_CFG_MASK_R1      1
`define TLA_CFG_MASK_R2      0
`define TLA_CONSEC_MASK_LOC  5

// status bit positions
`define TLA_ST_LOC_HIGH      6
`define TLA_ST_LOC_LOW       5
`define TLA_ST_REM_HIGH      4
`define TLA_ST_REM_LOW       3
`define TLA_ST_OPEN          2

// channel numbers
`define TLA_CH_LOCAL         2'd0
`define TLA_CH_R1            2'd1
`define TLA_CH_R2            2'd2
`define TLA_NUM_CH           3

// reset values
`define TLA_FS_DEFAULT       8'h55
`define TLA_HYST_DEFAULT     8'h0A
`define TLA_HIGH_DEFAULT     8'h7F
`define TLA_LOW_DEFAULT      8'h00
`define TLA_CFG_DEFAULT      8'h00

// bus answers
`define TLA_RESP_OKAY        2'b00
`define TLA_RESP_SLVERR      2'b10

`endif

/* hw/tla_pkg.sv */
package tla_pkg;
	typedef logic [7:0] tla_temp_type;
	typedef logic [1:0] tla_chan_type;
	typedef logic [2:0] tla_chan_mask_type;
endpackage

/* hw/tla_cmp_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface tla_cmp_if;
	logic                             ce;
	logic                             conv_valid;
	tla_pkg::tla_chan_type            conv_chan;
	tla_pkg::tla_temp_type            conv_temp;
	tla_pkg::tla_temp_type [2:0]      hi_lim;
	tla_pkg::tla_temp_type [2:0]      lo_lim;
	tla_pkg::tla_temp_type [2:0]      fs_lim;
	tla_pkg::tla_temp_type            hyst;
	tla_pkg::tla_chan_mask_type       done;
	tla_pkg::tla_chan_mask_type       high_now;
	tla_pkg::tla_chan_mask_type       low_now;
	tla_pkg::tla_chan_mask_type       failsafe_overtemp_n_on;

	modport ctrl (
		output ce, conv_valid, conv_chan, conv_temp, hi_lim, lo_lim, fs_lim, hyst,
		input  done, high_now, low_now, failsafe_overtemp_n_on
	);
	modport cmp (
		input  ce, conv_valid, conv_chan, conv_temp, hi_lim, lo_lim, fs_lim, hyst,
		output done, high_now, low_now, failsafe_overtemp_n_on
	);
endinterface
`default_nettype wire

/* hw/tla_compare.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tla_params.svh"
module tla_compare (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// comparator side
	tla_cmp_if.cmp    cmp
);
	genvar c;
	generate
		for (c = 0; c < `TLA_NUM_CH; c = c + 1) begin : g_ch
			logic hit;
			logic [8:0] rel_sum;
			assign hit = cmp.conv_valid && (cmp.conv_chan == 2'(c));
			assign rel_sum = {1'b0, cmp.conv_temp} + {1'b0, cmp.hyst};

			always_ff @(posedge sys_clk) begin
				if (rst) begin
					cmp.done[c] <= 1'b0;
				end else if (cmp.ce) begin
					cmp.done[c] <= hit;
				end
			end

			always_ff @(posedge sys_clk) begin
				if (rst) begin
					cmp.high_now[c] <= 1'b0;
					cmp.low_now[c]  <= 1'b0;
				end else if (cmp.ce && hit) begin
					cmp.high_now[c] <= cmp.conv_temp > cmp.hi_lim[c];
					cmp.low_now[c]  <= cmp.conv_temp <= cmp.lo_lim[c];
				end
			end

			always_ff @(posedge sys_clk) begin
				if (rst) begin
					cmp.failsafe_overtemp_n_on[c] <= 1'b0;
				end else if (cmp.ce && hit) begin
					if (cmp.conv_temp > cmp.fs_lim[c]) begin
						cmp.failsafe_overtemp_n_on[c] <= 1'b1;
					end else if (rel_sum <= {1'b0, cmp.fs_lim[c]}) begin
						cmp.failsafe_overtemp_n_on[c] <= 1'b0;
					end
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

/* hw/tla_alarm.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tla_params.svh"
module tla_alarm (
	// clock, reset, enable
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire logic                  clk_en,
	// conversion results
	input  wire logic                  conv_valid,
	input  wire tla_pkg::tla_chan_type conv_chan,
	input  wire tla_pkg::tla_temp_type conv_temp,
	// open-circuit comparator pins
	input  wire logic                  remote1_open_pin,
	input  wire logic                  remote2_open_pin,
	// alert response address read
	input  wire logic                  ara_read,
	// alarm pins
	output logic                       limit_alert_n,
	output logic                       failsafe_overtemp_n,
	// axi4-lite write address
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	// axi4-lite read data
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready
);
	tla_cmp_if cmp_bus ();

	tla_compare u_cmp (
		.sys_clk (sys_clk),
		.rst     (rst),
		.cmp     (cmp_bus.cmp)
	);

	// registers
	tla_pkg::tla_temp_type [2:0] hi_lim_reg;
	tla_pkg::tla_temp_type [2:0] lo_lim_reg;
	tla_pkg::tla_temp_type [2:0] temp_reg;
	tla_pkg::tla_temp_type       fs_local_reg;
	tla_pkg::tla_temp_type       fs_remote_reg;
	tla_pkg::tla_temp_type       hyst_reg;
	tla_pkg::tla_temp_type       cfg1_reg;
	tla_pkg::tla_temp_type       consec_reg;
	tla_pkg::tla_chan_mask_type  high_flag_reg;
	tla_pkg::tla_chan_mask_type  low_flag_reg;
	logic                        remote1_open_flag;
	logic                        remote2_open_flag;
	logic                        alert_reg;
	logic                        failsafe_reg;

	// pin synchronisers
	logic [2:0] open1_sync_reg;
	logic [2:0] open2_sync_reg;
	logic       open1_reg;
	logic       open2_reg;

	// bus state
	logic       aw_held_reg;
	logic       w_held_reg;
	logic [7:0] aw_addr_reg;
	logic [7:0] w_data_reg;
	logic       w_strb_reg;
	logic       wr_fire;
	logic       wr_hit;
	logic       rd_fire;
	logic       rd_hit;
	logic [7:0] rd_val;
	logic       rd_stat1;
	logic       rd_stat2;

	assign cmp_bus.ce         = clk_en;
	assign cmp_bus.conv_valid = conv_valid;
	assign cmp_bus.conv_chan  = conv_chan;
	assign cmp_bus.conv_temp  = conv_temp;
	assign cmp_bus.hi_lim     = hi_lim_reg;
	assign cmp_bus.lo_lim     = lo_lim_reg;
	assign cmp_bus.fs_lim     = {fs_remote_reg, fs_remote_reg, fs_local_reg};
	assign cmp_bus.hyst       = hyst_reg;

	// open pins: change counts once stages two and three agree
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			open1_sync_reg <= 3'h0;
			open2_sync_reg <= 3'h0;
			open1_reg      <= 1'b0;
			open2_reg      <= 1'b0;
		end else if (clk_en) begin
			open1_sync_reg <= {open1_sync_reg[1:0], remote1_open_pin};
			open2_sync_reg <= {open2_sync_reg[1:0], remote2_open_pin};
			if (open1_sync_reg[1] == open1_sync_reg[2]) begin
				open1_reg <= open1_sync_reg[2];
			end
			if (open2_sync_reg[1] == open2_sync_reg[2]) begin
				open2_reg <= open2_sync_reg[2];
			end
		end
	end

	// write channel capture
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
	assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			aw_held_reg  <= 1'b0;
			w_held_reg   <= 1'b0;
			aw_addr_reg  <= 8'h00;
			w_data_reg   <= 8'h00;
			w_strb_reg   <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `TLA_RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata[7:0];
				w_strb_reg <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `TLA_RESP_OKAY : `TLA_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// writable address decode
	always_comb begin
		wr_hit = (aw_addr_reg == `TLA_ADDR_CFG1) || (aw_addr_reg == `TLA_ADDR_CONSEC)
			|| (aw_addr_reg == `TLA_ADDR_FS_LOCAL) || (aw_addr_reg == `TLA_ADDR_FS_REMOTE)
			|| (aw_addr_reg == `TLA_ADDR_HYST);
		for (int i = 0; i < `TLA_NUM_CH; i++) begin
			if (aw_addr_reg == `TLA_ADDR_LIM_BASE + 8'(i) * `TLA_LIM_STRIDE) begin
				wr_hit = 1'b1;
			end
			if (aw_addr_reg == `TLA_ADDR_LIM_BASE + 8'(i) * `TLA_LIM_STRIDE + `TLA_LIM_LOW_OFS) begin
				wr_hit = 1'b1;
			end
		end
	end

	// configuration and masks
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cfg1_reg   <= `TLA_CFG_DEFAULT;
			consec_reg <= `TLA_CFG_DEFAULT;
		end else if (clk_en && wr_fire && w_strb_reg) begin
			if (aw_addr_reg == `TLA_ADDR_CFG1) begin
				cfg1_reg <= w_data_reg;
			end
			if (aw_addr_reg == `TLA_ADDR_CONSEC) begin
				consec_reg <= w_data_reg;
			end
		end
	end

	// fail-safe limits and hysteresis
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			fs_local_reg  <= `TLA_FS_DEFAULT;
			fs_remote_reg <= `TLA_FS_DEFAULT;
			hyst_reg      <= `TLA_HYST_DEFAULT;
		end else if (clk_en && wr_fire && w_strb_reg) begin
			if (aw_addr_reg == `TLA_ADDR_FS_LOCAL) begin
				fs_local_reg <= w_data_reg;
			end
			if (aw_addr_reg == `TLA_ADDR_FS_REMOTE) begin
				fs_remote_reg <= w_data_reg;
			end
			if (aw_addr_reg == `TLA_ADDR_HYST) begin
				hyst_reg <= w_data_reg;
			end
		end
	end

	// alarm limits and result readback
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			hi_lim_reg <= {3{`TLA_HIGH_DEFAULT}};
			lo_lim_reg <= {3{`TLA_LOW_DEFAULT}};
			temp_reg   <= {3{8'h00}};
		end else if (clk_en) begin
			for (int i = 0; i < `TLA_NUM_CH; i++) begin
				if (wr_fire && w_strb_reg
					&& aw_addr_reg == `TLA_ADDR_LIM_BASE + 8'(i) * `TLA_LIM_STRIDE) begin
					hi_lim_reg[i] <= w_data_reg;
				end
				if (wr_fire && w_strb_reg
					&& aw_addr_reg == `TLA_ADDR_LIM_BASE + 8'(i) * `TLA_LIM_STRIDE + `TLA_LIM_LOW_OFS) begin
					lo_lim_reg[i] <= w_data_reg;
				end
				if (conv_valid && conv_chan == 2'(i)) begin
					temp_reg[i] <= conv_temp;
				end
			end
		end
	end

	// read channel
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;
	assign rd_stat1      = rd_fire && s_axi_araddr == `TLA_ADDR_STAT1;
	assign rd_stat2      = rd_fire && s_axi_araddr == `TLA_ADDR_STAT2;

	always_comb begin
		rd_hit = 1'b1;
		rd_val = 8'h00;
		unique case (s_axi_araddr)
			`TLA_ADDR_CFG1:      rd_val = cfg1_reg;
			`TLA_ADDR_CONSEC:    rd_val = consec_reg;
			`TLA_ADDR_FS_LOCAL:  rd_val = fs_local_reg;
			`TLA_ADDR_FS_REMOTE: rd_val = fs_remote_reg;
			`TLA_ADDR_HYST:      rd_val = hyst_reg;
			`TLA_ADDR_STAT1: begin
				rd_val[`TLA_ST_LOC_HIGH] = high_flag_reg[0];
				rd_val[`TLA_ST_LOC_LOW]  = low_flag_reg[0];
				rd_val[`TLA_ST_REM_HIGH] = high_flag_reg[1];
				rd_val[`TLA_ST_REM_LOW]  = low_flag_reg[1];
				rd_val[`TLA_ST_OPEN]     = remote1_open_flag;
			end
			`TLA_ADDR_STAT2: begin
				rd_val[`TLA_ST_REM_HIGH] = high_flag_reg[2];
				rd_val[`TLA_ST_REM_LOW]  = low_flag_reg[2];
				rd_val[`TLA_ST_OPEN]     = remote2_open_flag;
			end
			default: begin
				rd_hit = 1'b0;
				for (int i = 0; i < `TLA_NUM_CH; i++) begin
					if (s_axi_araddr == `TLA_ADDR_LIM_BASE + 8'(i) * `TLA_LIM_STRIDE) begin
						rd_hit = 1'b1;
						rd_val = hi_lim_reg[i];
					end
					if (s_axi_araddr == `TLA_ADDR_LIM_BASE + 8'(i) * `TLA_LIM_STRIDE + `TLA_LIM_LOW_OFS) begin
						rd_hit = 1'b1;
						rd_val = lo_lim_reg[i];
					end
					if (s_axi_araddr == `TLA_ADDR_TEMP_BASE + 8'(i) * `TLA_TEMP_STRIDE) begin
						rd_hit = 1'b1;
						rd_val = temp_reg[i];
					end
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `TLA_RESP_OKAY;
		end else if (clk_en) begin
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {24'h000000, rd_val};
				s_axi_rresp  <= rd_hit ? `TLA_RESP_OKAY : `TLA_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// status flags latch until read; a set wins over the read clear
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			high_flag_reg     <= 3'h0;
			low_flag_reg      <= 3'h0;
			remote1_open_flag <= 1'b0;
			remote2_open_flag <= 1'b0;
		end else if (clk_en) begin
			for (int i = 0; i < `TLA_NUM_CH; i++) begin
				if (cmp_bus.done[i] && (cmp_bus.high_now[i] || cmp_bus.low_now[i])) begin
					high_flag_reg[i] <= high_flag_reg[i] | cmp_bus.high_now[i];
					low_flag_reg[i]  <= low_flag_reg[i] | cmp_bus.low_now[i];
				end else if ((i == 2) ? rd_stat2 : rd_stat1) begin
					high_flag_reg[i] <= 1'b0;
					low_flag_reg[i]  <= 1'b0;
				end
			end
			if (cmp_bus.done[1] && open1_reg) begin
				remote1_open_flag <= 1'b1;
			end else if (rd_stat1) begin
				remote1_open_flag <= 1'b0;
			end
			if (cmp_bus.done[2] && open2_reg) begin
				remote2_open_flag <= 1'b1;
			end else if (rd_stat2) begin
				remote2_open_flag <= 1'b0;
			end
		end
	end

	// alarm causes per channel
	tla_pkg::tla_chan_mask_type ch_mask;
	tla_pkg::tla_chan_mask_type ch_cause;
	logic                       alert_cause;

	// local, remote 1, remote 2 masks
	assign ch_mask = {cfg1_reg[`TLA_CFG_MASK_R2], cfg1_reg[`TLA_CFG_MASK_R1],
		consec_reg[`TLA_CONSEC_MASK_LOC]};
	assign ch_cause = (high_flag_reg | low_flag_reg | cmp_bus.high_now | cmp_bus.low_now
		| {remote2_open_flag, remote1_open_flag, 1'b0}) & ~ch_mask;
	assign alert_cause = (|ch_cause) && !cfg1_reg[`TLA_CFG_MASK_ALL];

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			alert_reg <= 1'b0;
		end else if (clk_en) begin
			if (alert_cause) begin
				alert_reg <= 1'b1;
			// release on address read once clear
			end else if (ara_read) begin
				alert_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			failsafe_reg <= 1'b0;
		end else if (clk_en) begin
			failsafe_reg <= |cmp_bus.failsafe_overtemp_n_on;
		end
	end

	assign limit_alert_n       = !alert_reg;
	assign failsafe_overtemp_n = !failsafe_reg;
endmodule
`default_nettype wire

/* tb/tla_props.sv */
`timescale 1ns/1ps
`default_nettype none
module tla_props (
	// clock, reset, enable
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	// results and pins
	input wire logic conv_valid,
	input wire logic ara_read,
	input wire logic limit_alert_n,
	input wire logic failsafe_overtemp_n,
	// bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst || !clk_en);
	AST_ALERT_HOLD: assert property (!limit_alert_n && !ara_read |=> !limit_alert_n)
		else $error("alert released without service");
	AST_FS_SET: assert property ($fell(failsafe_overtemp_n) |-> $past(conv_valid, 2))
		else $error("fail-safe set without result");
	AST_FS_CLR: assert property ($rose(failsafe_overtemp_n) |-> $past(conv_valid, 2))
		else $error("fail-safe cleared without result");
	AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	AST_W_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during data");
	AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data repeated");
	cover property ($fell(limit_alert_n));
	cover property ($rose(limit_alert_n));
	cover property ($rose(failsafe_overtemp_n));
endmodule
bind tla_alarm tla_props u_tla_props (.sys_clk, .rst, .clk_en, .conv_valid, .ara_read, .limit_alert_n,
	.failsafe_overtemp_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

/* tb/tla_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tla_host_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// alert line and service pulse
	input wire logic limit_alert_n,
	output logic     ara_read
);
	logic [2:0] gap_reg;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			gap_reg  <= 3'h0;
			ara_read <= 1'b0;
		end else begin
			gap_reg  <= gap_reg + 3'h1;
			ara_read <= !limit_alert_n && gap_reg == 3'h7;
		end
	end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, conv_valid = 1'b0;
	logic        remote1_open_pin = 1'b0, remote2_open_pin = 1'b0;
	logic [1:0]  conv_chan = 2'h0;
	logic [7:0]  conv_temp = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, lim, hy;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic        ara_read, limit_alert_n, failsafe_overtemp_n, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [33:0] rd_q[$];
	logic [1:0]  wr_q[$];
	logic [7:0]  mk_a[4] = '{8'h04, 8'h00, 8'h00, 8'h00};
	logic [7:0]  mk_v[4] = '{8'h20, 8'h02, 8'h01, 8'h80};
	logic [1:0]  mk_c[4] = '{2'h0, 2'h1, 2'h2, 2'h2};
	int          errors = 0, n_compared = 0, cyc = 0;

	always #5 sys_clk = ~sys_clk;

	tla_alarm u_tla_alarm (.sys_clk, .rst, .clk_en, .conv_valid, .conv_chan, .conv_temp, .remote1_open_pin,
		.remote2_open_pin, .ara_read, .limit_alert_n, .failsafe_overtemp_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	tla_host_model u_tla_host_model (.sys_clk, .rst, .limit_alert_n, .ara_read);

	task automatic report_and_stop;
		$display("errors=%0d compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic note(input logic ok, input string what);
		n_compared++;
		if (ok !== 1'b1) begin
			errors++;
			$display("BAD %0t %s", $time, what);
		end
	endtask
	task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
		note(g === e, "read data");
	endtask
	task automatic cmp_wr(input logic [1:0] e, input logic [1:0] g);
		note(g === e, "write response");
	endtask
	task automatic cmp_pin(input logic e, input logic g);
		note(g === e, "alarm pin");
	endtask
	// bus master, both channels offered together
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'b00, input logic [3:0] s = 4'hF);
		logic aw_p;
		logic w_p;
		wr_q.push_back(r);
		aw_p = 1'b1;
		w_p = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'($urandom()), d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (aw_p || w_p || !s_axi_bvalid) begin
			@(posedge sys_clk);
			if (aw_p && s_axi_awready) begin
				aw_p = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w_p && s_axi_wready) begin
				w_p = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'b00);
		rd_q.push_back({r, 24'h0, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge sys_clk); while (!s_axi_rvalid);
	endtask
	task automatic conv(input logic [1:0] c, input logic [7:0] t);
		conv_chan <= c;
		conv_temp <= t;
		conv_valid <= 1'b1;
		@(posedge sys_clk);
		conv_valid <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic released;
		for (int i = 0; i < 40 && limit_alert_n !== 1'b1; i++) @(posedge sys_clk);
	endtask

	// result monitor and run limit
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			report_and_stop();
		end
		if (!rst && s_axi_rvalid && s_axi_rready) cmp_rd(rd_q.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (!rst && s_axi_bvalid && s_axi_bready) cmp_wr(wr_q.pop_front(), s_axi_bresp);
	end

	initial begin
		void'($urandom(32'h2107));
		lim = 8'($urandom_range(32'h6F, 32'h40));
		hy = 8'($urandom_range(32'hF, 32'h1));
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rd(8'h28, 8'h55);
		rd(8'h2C, 8'h55);
		rd(8'h30, 8'h0A);
		rd(8'h00, 8'h00);
		rd(8'h04, 8'h00);
		rd(8'hFC, 8'h00, 2'b10);
		wr(8'h08, 8'hFF, 2'b10);
		wr(8'h30, hy);
		wr(8'h28, lim);
		wr(8'h2C, lim);
		for (int c = 0; c < 3; c++) begin
			wr(8'(8'h10 + 8 * c), lim);
			conv(2'(c), lim);
			cmp_pin(1'b1, failsafe_overtemp_n);
			conv(2'(c), lim + 8'h1);
			cmp_pin(1'b0, failsafe_overtemp_n);
			cmp_pin(1'b0, limit_alert_n);
			conv(2'(c), lim - hy + 8'h1);
			cmp_pin(1'b0, failsafe_overtemp_n);
			conv(2'(c), lim - hy);
			cmp_pin(1'b1, failsafe_overtemp_n);
		end
		repeat (20) @(posedge sys_clk);
		cmp_pin(1'b0, limit_alert_n);
		rd(8'h08, 8'h50);
		rd(8'h0C, 8'h10);
		released();
		cmp_pin(1'b1, limit_alert_n);
		for (int m = 0; m < 4; m++) begin
			wr(mk_a[m], mk_v[m]);
			conv(mk_c[m], lim + 8'h1);
			cmp_pin(1'b1, limit_alert_n);
			cmp_pin(1'b0, failsafe_overtemp_n);
			conv(mk_c[m], lim - hy);
			rd(8'h08, mk_c[m] == 2'h0 ? 8'h40 : mk_c[m] == 2'h1 ? 8'h10 : 8'h00);
			rd(8'h0C, mk_c[m] == 2'h2 ? 8'h10 : 8'h00);
			wr(mk_a[m], 8'h00);
			cmp_pin(1'b1, limit_alert_n);
		end
		wr(8'h24, 8'h20);
		conv(2'h2, 8'h21);
		cmp_pin(1'b1, limit_alert_n);
		conv(2'h2, 8'h20);
		cmp_pin(1'b0, limit_alert_n);
		conv(2'h2, 8'h21);
		rd(8'h0C, 8'h08);
		released();
		cmp_pin(1'b1, limit_alert_n);
		for (int c = 1; c < 3; c++) begin
			remote1_open_pin <= c == 1;
			remote2_open_pin <= c == 2;
			repeat (6) @(posedge sys_clk);
			conv(2'(c), 8'h30);
			cmp_pin(1'b0, limit_alert_n);
			remote1_open_pin <= 1'b0;
			remote2_open_pin <= 1'b0;
			repeat (6) @(posedge sys_clk);
			conv(2'(c), 8'h30);
			rd(c == 1 ? 8'h08 : 8'h0C, 8'h04);
			released();
			cmp_pin(1'b1, limit_alert_n);
		end
		clk_en <= 1'b0;
		conv(2'h1, 8'hFF);
		clk_en <= 1'b1;
		cmp_pin(1'b1, failsafe_overtemp_n);
		conv(2'h3, 8'hFF);
		cmp_pin(1'b1, failsafe_overtemp_n);
		cmp_pin(1'b1, limit_alert_n);
		wr(8'h30, 8'h03, 2'b00, 4'hE);
		rd(8'h30, hy);
		rd(8'h38, 8'h30);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rd(8'h30, 8'h0A);
		repeat (4) @(posedge sys_clk);
		report_and_stop();
	end
endmodule
`default_nettype wire
